// ===== src/wdrs_top.sv
// Watchdog timer with reset sequencing and reset-source flags.
`timescale 1ns/1ps
module wdrs_top #(
  parameter int FLASH_INIT_CYC = wdrs_pkg::FLASH_INIT_CYC
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 reset_input_pin_n_i,
  input  wire logic                 reset_discharge_pin_i,
  input  wire logic                 external_boot_pin_n_i,
  input  wire logic                 end_of_init_instr_i,
  input  wire logic                 software_reset_instr_i,
  input  wire logic                 service_i,
  input  wire logic                 disable_i,
  input  wire logic                 ctrl_wr_i,
  input  wire logic [7:0]           counter_reload_value_i,
  input  wire logic                 prescale_select_bit_i,
  input  wire logic                 bidir_reset_enable_set_i,
  output wdrs_pkg::wdrs_ctrl_t      watchdog_control_reg_o,
  output logic [15:0]               wdt_count_o,
  output logic                      wdt_enabled_o,
  output logic                      bidir_reset_enable_o,
  output logic                      reset_output_pin_n_o,
  output logic                      reset_input_pin_o,
  output logic                      reset_input_pin_oe_o,
  output logic                      internal_reset_o,
  output logic                      async_quiesce_o,
  output logic                      flash_ready_o,
  output logic [15:0]               flash_read_data_o
);
  import wdrs_pkg::*;

  if (FLASH_INIT_CYC < 2 || FLASH_INIT_CYC > 65535) begin : g_bad_flash_init
    $error("wdrs_top: bad FLASH_INIT_CYC");
  end

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  wdrs_state_t state_reg;
  logic [15:0] cnt_reg;
  logic        src_hw_reg;
  logic        filtered_reset_input_n;
  logic        wdt_ovf;
  logic        wdt_en_reg;
  logic        end_of_init_instr_done_reg;
  logic        bidir_reg;
  logic [15:0] flash_cnt_reg;
  logic        flash_ready_reg;
  logic [15:0] count;
  wdrs_ctrl_t  ctrl_reg;
  logic        in_reset;
  logic        hw_async;
  logic        run_soft;
  logic        boot_done;

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  function automatic logic last_cycle(input logic [15:0] cnt, input int len);
    last_cycle = (cnt == 16'(len - 1));
  endfunction : last_cycle

  assign in_reset = (state_reg != ST_RUN);
  // A hardware reset becomes asynchronous as soon as discharge reads low.
  assign hw_async = !filtered_reset_input_n && !reset_discharge_pin_i;
  assign run_soft = wdt_ovf || software_reset_instr_i;
  assign boot_done = external_boot_pin_n_i ? flash_ready_reg
                                           : last_cycle(cnt_reg, EXT_BOOT_CYC);

  // -------------------------------------------------------------------------
  // Input filter
  // -------------------------------------------------------------------------
  wdrs_filter #(
    .STABLE_CYC (FILTER_CYC)
  ) u_filter (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .raw_n_i    (reset_input_pin_n_i),
    .filt_n_o   (filtered_reset_input_n)
  );

  // -------------------------------------------------------------------------
  // Watchdog counter
  // -------------------------------------------------------------------------
  wdrs_counter #(
    .W           (WDT_W)
  ) u_counter (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .clear_i     (in_reset),
    .enable_i    (wdt_en_reg),
    .prescale_i  (ctrl_reg.prescale_select_bit),
    .reload_i    (ctrl_reg.counter_reload_value),
    .service_i   (service_i && !in_reset),
    .count_o     (count),
    .overflow_o  (wdt_ovf)
  );

  // -------------------------------------------------------------------------
  // Reset sequencer
  // -------------------------------------------------------------------------
  // The power-on state waits in the asynchronous reset until the filtered
  // input is high, so no clock edge is needed to enter it.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg  <= ST_ASYNC;
      cnt_reg    <= 16'h0000;
      src_hw_reg <= 1'b1;
    end else begin
      case (state_reg)
        ST_RUN: begin
          cnt_reg <= 16'h0000;
          if (hw_async) begin
            state_reg  <= ST_ASYNC;
            src_hw_reg <= 1'b1;
          end else if (!filtered_reset_input_n) begin
            state_reg  <= ST_DETECT;
            src_hw_reg <= 1'b1;
          end else if (run_soft) begin
            state_reg  <= ST_DETECT;
            src_hw_reg <= 1'b0;
          end
        end
        ST_DETECT: begin
          if (src_hw_reg && hw_async) begin
            state_reg <= ST_ASYNC;
          end else if (last_cycle(cnt_reg, DETECT_CYC)) begin
            state_reg <= ST_SEQ;
            cnt_reg   <= 16'h0000;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        ST_SEQ: begin
          if (src_hw_reg && hw_async) begin
            state_reg <= ST_ASYNC;
          end else if (last_cycle(cnt_reg, SEQ_CYC)) begin
            state_reg <= ST_SAMPLE;
            cnt_reg   <= 16'h0000;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        ST_SAMPLE: begin
          if (src_hw_reg && hw_async) begin
            state_reg <= ST_ASYNC;
          end else if (last_cycle(cnt_reg, SAMPLE_CYC)) begin
            state_reg <= ST_WAIT;
            cnt_reg   <= 16'h0000;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        ST_WAIT: begin
          cnt_reg <= 16'h0000;
          if (src_hw_reg && hw_async) begin
            state_reg <= ST_ASYNC;
          end else if (filtered_reset_input_n) begin
            state_reg <= ST_BOOT;
          end
        end
        ST_ASYNC: begin
          cnt_reg <= 16'h0000;
          if (filtered_reset_input_n) begin
            state_reg <= ST_BOOT;
          end
        end
        ST_BOOT: begin
          if (!filtered_reset_input_n) begin
            state_reg <= reset_discharge_pin_i ? ST_DETECT : ST_ASYNC;
            cnt_reg   <= 16'h0000;
            src_hw_reg <= 1'b1;
          end else if (boot_done) begin
            state_reg <= ST_RUN;
            cnt_reg   <= 16'h0000;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        default: begin
          state_reg <= ST_ASYNC;
          cnt_reg   <= 16'h0000;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Control register and reset-source flags
  // -------------------------------------------------------------------------
  // Flags are only cleared while running, except that a short hardware reset clears the long
  // hardware flag at its sample; the timeout, software and long hardware flags can also be set in run; a set takes priority over a clear.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
    end else begin
      if (ctrl_wr_i && !in_reset) begin
        ctrl_reg.counter_reload_value <= counter_reload_value_i;
        ctrl_reg.prescale_select_bit  <= prescale_select_bit_i;
      end else if (in_reset) begin
        ctrl_reg.counter_reload_value <= CTRL_RST.counter_reload_value;
        ctrl_reg.prescale_select_bit  <= CTRL_RST.prescale_select_bit;
      end
      if (end_of_init_instr_i && !in_reset) begin
        ctrl_reg.power_on_flag       <= 1'b0;
        ctrl_reg.long_hardware_flag  <= 1'b0;
        ctrl_reg.short_hardware_flag <= 1'b0;
        ctrl_reg.timeout_reset_flag  <= 1'b0;
        ctrl_reg.software_reset_flag <= 1'b0;
      end
      if (state_reg == ST_RUN && !hw_async && filtered_reset_input_n && wdt_ovf) begin
        ctrl_reg.timeout_reset_flag <= 1'b1;
      end
      if (state_reg == ST_RUN && !hw_async && filtered_reset_input_n && !wdt_ovf
          && software_reset_instr_i) begin
        ctrl_reg.software_reset_flag <= 1'b1;
      end
      if (src_hw_reg && state_reg == ST_SAMPLE && last_cycle(cnt_reg, SAMPLE_CYC)
          && !hw_async) begin
        ctrl_reg.short_hardware_flag <= 1'b1;
        ctrl_reg.long_hardware_flag  <= !filtered_reset_input_n;
      end
      if (state_reg != ST_ASYNC && hw_async
          && (src_hw_reg || state_reg == ST_RUN || state_reg == ST_BOOT)) begin
        ctrl_reg.long_hardware_flag <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Watchdog enable and end of initialisation
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_en_reg     <= 1'b1;
      end_of_init_instr_done_reg <= 1'b0;
    end else if (in_reset) begin
      wdt_en_reg     <= 1'b1;
      end_of_init_instr_done_reg <= 1'b0;
    end else begin
      if (end_of_init_instr_i) begin
        end_of_init_instr_done_reg <= 1'b1;
      end
      if (disable_i && !end_of_init_instr_done_reg && !end_of_init_instr_i) begin
        wdt_en_reg <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Bidirectional reset enable and reset pin drive
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bidir_reg <= 1'b0;
    end else if (state_reg == ST_BOOT && boot_done && filtered_reset_input_n) begin
      bidir_reg <= 1'b0;
    end else if (bidir_reset_enable_set_i && !in_reset) begin
      bidir_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_input_pin_oe_o <= 1'b0;
    end else begin
      // Soft resets drive the pin only while the discharge pin reads high.
      reset_input_pin_oe_o <= bidir_reg
                              && (state_reg == ST_DETECT || state_reg == ST_SEQ)
                              && (src_hw_reg || reset_discharge_pin_i);
    end
  end

  // -------------------------------------------------------------------------
  // Flash initialisation model
  // -------------------------------------------------------------------------
  // Initialisation restarts on every reset and runs from the entry into ST_BOOT.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_cnt_reg   <= 16'h0000;
      flash_ready_reg <= 1'b0;
    end else if (state_reg != ST_RUN && state_reg != ST_BOOT) begin
      flash_cnt_reg   <= 16'h0000;
      flash_ready_reg <= 1'b0;
    end else if (!flash_ready_reg) begin
      if (last_cycle(flash_cnt_reg, FLASH_INIT_CYC)) begin
        flash_ready_reg <= 1'b1;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_read_data_o <= FLASH_BLANK;
      flash_ready_o     <= 1'b0;
    end else begin
      flash_ready_o <= flash_ready_reg;
      if (flash_cnt_reg < 16'(FLASH_INIT_CYC / 2)) begin
        flash_read_data_o <= FLASH_BLANK;
      end else begin
        flash_read_data_o <= FLASH_FILL;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Registered outputs
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_output_pin_n_o <= 1'b0;
      internal_reset_o     <= 1'b1;
      async_quiesce_o      <= 1'b1;
    end else begin
      internal_reset_o <= in_reset;
      async_quiesce_o  <= (state_reg == ST_ASYNC);
      if (in_reset) begin
        reset_output_pin_n_o <= 1'b0;
      end else if (end_of_init_instr_i) begin
        reset_output_pin_n_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      watchdog_control_reg_o <= CTRL_RST;
      wdt_count_o            <= 16'h0000;
      wdt_enabled_o          <= 1'b1;
      bidir_reset_enable_o   <= 1'b0;
      reset_input_pin_o      <= 1'b0;
    end else begin
      watchdog_control_reg_o <= ctrl_reg;
      wdt_count_o            <= count;
      wdt_enabled_o          <= wdt_en_reg;
      bidir_reset_enable_o   <= bidir_reg;
      reset_input_pin_o      <= 1'b0;
    end
  end

endmodule : wdrs_top

// ===== src/wdrs_pkg.sv
// Shared constants and types for the watchdog and reset-source logic.
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package wdrs_pkg;

  // -------------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------------
  localparam int CLK_HZ          = 50_000_000;
  localparam int CLK_NS          = 1_000_000_000 / CLK_HZ;
  localparam int FILTER_NS       = 50;
  localparam int DETECT_TCL      = 12;
  localparam int SEQ_TCL         = 1024;
  localparam int SAMPLE_TCL      = 8;
  localparam int EXT_BOOT_TCL    = 8;
  localparam int FLASH_INIT_US   = 1000;
  // One CPU period holds two half periods.
  localparam int FILTER_CYC      = (FILTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int DETECT_CYC      = DETECT_TCL / 2;
  localparam int SEQ_CYC         = SEQ_TCL / 2;
  localparam int SAMPLE_CYC      = SAMPLE_TCL / 2;
  localparam int EXT_BOOT_CYC    = EXT_BOOT_TCL / 2;
  localparam int FLASH_INIT_CYC  = FLASH_INIT_US * (CLK_HZ / 1_000_000);

  // -------------------------------------------------------------------------
  // Watchdog
  // -------------------------------------------------------------------------
  localparam int          WDT_W        = 16;
  localparam int          DIV_FAST     = 2;
  localparam int          DIV_SLOW     = 128;
  localparam logic [15:0] FLASH_BLANK  = 16'hffff;
  localparam logic [15:0] FLASH_FILL   = 16'h009b;

  typedef struct packed {
    logic [7:0] counter_reload_value;
    logic       power_on_flag;
    logic       long_hardware_flag;
    logic       short_hardware_flag;
    logic       timeout_reset_flag;
    logic       software_reset_flag;
    logic       prescale_select_bit;
  } wdrs_ctrl_t;

  localparam wdrs_ctrl_t CTRL_RST = '{8'h00, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_DETECT = 3'b001,
    ST_SEQ    = 3'b011,
    ST_SAMPLE = 3'b010,
    ST_WAIT   = 3'b110,
    ST_BOOT   = 3'b111,
    ST_ASYNC  = 3'b101
  } wdrs_state_t;

endpackage : wdrs_pkg

// ===== src/wdrs_filter.sv
// Digital spike filter for the active-low reset input.
`timescale 1ns/1ps
module wdrs_filter #(
  parameter int STABLE_CYC = wdrs_pkg::FILTER_CYC
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic raw_n_i,
  output logic      filt_n_o
);
  import wdrs_pkg::*;

  if (STABLE_CYC < 1 || STABLE_CYC > 255) begin : g_bad_stable
    $error("wdrs_filter: bad STABLE_CYC");
  end

  logic [7:0] cnt_reg;

  // -------------------------------------------------------------------------
  // Output follows the input only after it has held for STABLE_CYC cycles.
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg  <= 8'h00;
      filt_n_o <= 1'b0;
    end else if (raw_n_i == filt_n_o) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg == 8'(STABLE_CYC - 1)) begin
      cnt_reg  <= 8'h00;
      filt_n_o <= raw_n_i;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

endmodule : wdrs_filter

// ===== src/wdrs_counter.sv
// Watchdog prescaler and 16-bit counter with overflow pulse.
`timescale 1ns/1ps
module wdrs_counter #(
  parameter int W = wdrs_pkg::WDT_W
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic         clear_i,
  input  wire logic         enable_i,
  input  wire logic         prescale_i,
  input  wire logic [7:0]   reload_i,
  input  wire logic         service_i,
  output logic [W-1:0]      count_o,
  output logic              overflow_o
);
  import wdrs_pkg::*;

  if (W != 16) begin : g_bad_width
    $error("wdrs_counter: counter must be 16 bits");
  end

  logic [6:0] div_reg;
  logic       tick;

  assign tick = (div_reg == (prescale_i ? 7'(DIV_SLOW - 1) : 7'(DIV_FAST - 1)));

  // -------------------------------------------------------------------------
  // Prescaler.
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= 7'h00;
    end else if (clear_i || !enable_i || service_i || tick) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end

  // -------------------------------------------------------------------------
  // Counter, service reload and overflow.
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o    <= '0;
      overflow_o <= 1'b0;
    end else begin
      overflow_o <= 1'b0;
      if (clear_i) begin
        count_o <= '0;
      end else if (service_i) begin
        count_o <= {reload_i, 8'h00};
      end else if (enable_i && tick) begin
        count_o    <= count_o + 1'b1;
        overflow_o <= &count_o;
      end
    end
  end

endmodule : wdrs_counter

// ===== dv/wdrs_checker.sv
// Concurrent checks on the ports of the watchdog and reset-source top module.
`timescale 1ns/1ps
module wdrs_checker #(
  parameter int FLASH_INIT_CYC = 20
) (
  input wire logic                 ref_clk_i,
  input wire logic                 rst_i,
  input wire logic                 reset_input_pin_n_i,
  input wire logic                 end_of_init_instr_i,
  input wire logic                 service_i,
  input wire wdrs_pkg::wdrs_ctrl_t watchdog_control_reg_o,
  input wire logic [15:0]          wdt_count_o,
  input wire logic                 wdt_enabled_o,
  input wire logic                 bidir_reset_enable_o,
  input wire logic                 reset_output_pin_n_o,
  input wire logic                 reset_input_pin_o,
  input wire logic                 reset_input_pin_oe_o,
  input wire logic                 internal_reset_o,
  input wire logic                 async_quiesce_o
);
  import wdrs_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_run;
    !internal_reset_o && reset_output_pin_n_o;
  endsequence
  sequence s_spike;
    s_run ##0 $fell(reset_input_pin_n_i) ##1 reset_input_pin_n_i;
  endsequence
  chk_service_load: assert property (s_run ##0 service_i |-> ##2 wdt_count_o[7:0] == 8'h00)
    else $error("service left the low byte set");
  chk_spike_filter: assert property (s_spike |-> !internal_reset_o [*8])
    else $error("short spike caused a reset");
  chk_init_clear: assert property (!internal_reset_o && end_of_init_instr_i |->
    ##2 watchdog_control_reg_o[5:1] == 5'h00) else $error("flags survived end of init");
  chk_timeout_flag: assert property (!internal_reset_o && wdt_enabled_o &&
    wdt_count_o == 16'hffff |-> ##[1:140] (watchdog_control_reg_o.timeout_reset_flag || service_i))
    else $error("overflow did not flag a timeout");
  chk_reset_output_pin_low: assert property (internal_reset_o |-> !reset_output_pin_n_o)
    else $error("reset output high during reset");
  chk_exit_state: assert property ($fell(internal_reset_o) |-> wdt_enabled_o &&
    !bidir_reset_enable_o) else $error("bad state on leaving reset");
  chk_pin_drive: assert property (reset_input_pin_oe_o |-> !reset_input_pin_o &&
    bidir_reset_enable_o) else $error("reset pin driven without enable");
  chk_async_hold: assert property (async_quiesce_o |=> internal_reset_o &&
    !reset_output_pin_n_o) else $error("quiesce outside reset");
endmodule : wdrs_checker
bind wdrs_top wdrs_checker #(.FLASH_INIT_CYC(FLASH_INIT_CYC)) wdrs_checker_i (
  .ref_clk_i, .rst_i, .reset_input_pin_n_i, .end_of_init_instr_i, .service_i,
  .watchdog_control_reg_o, .wdt_count_o, .wdt_enabled_o, .bidir_reset_enable_o,
  .reset_output_pin_n_o, .reset_input_pin_o, .reset_input_pin_oe_o, .internal_reset_o,
  .async_quiesce_o);

// ===== dv/wdrs_supervisor.sv
// External reset supervisor model for the reset input and discharge pins.
`timescale 1ns/1ps
module wdrs_supervisor (
  input  wire logic hold_low_i,
  input  wire logic discharge_low_i,
  input  wire logic dev_oe_i,
  input  wire logic dev_drv_i,
  output logic      reset_input_pin_n_o,
  output logic      reset_discharge_pin_o
);
  // The reset pin has a pull-up, so it reads high unless some party pulls it low.
  assign reset_input_pin_n_o = !(hold_low_i || (dev_oe_i && !dev_drv_i));
  assign reset_discharge_pin_o = !discharge_low_i;
endmodule : wdrs_supervisor

// ===== dv/wdrs_top_bench.sv
// Self-checking bench for the watchdog and reset-source logic.
`timescale 1ns/1ps
module wdrs_top_bench;
  import wdrs_pkg::*;
  localparam int FI = 20;
  logic        clk, rst, hold, dlow, boot_n, pres, oe, drv, pin_n, reset_discharge_pin, seen_oe;
  logic        en, bidir, rout_n, irst, quiesce, fready;
  logic [5:0]  req;
  logic [7:0]  rel;
  logic [15:0] cnt, fdata;
  wdrs_ctrl_t  f;
  int          n_errors, comparisons, n;
  wdrs_top #(.FLASH_INIT_CYC(FI)) wdrs_top_i (.ref_clk_i(clk), .rst_i(rst),
    .reset_input_pin_n_i(pin_n), .reset_discharge_pin_i(reset_discharge_pin), .external_boot_pin_n_i(boot_n),
    .end_of_init_instr_i(req[0]), .software_reset_instr_i(req[1]), .service_i(req[2]),
    .disable_i(req[3]), .ctrl_wr_i(req[4]), .counter_reload_value_i(rel),
    .prescale_select_bit_i(pres), .bidir_reset_enable_set_i(req[5]),
    .watchdog_control_reg_o(f), .wdt_count_o(cnt), .wdt_enabled_o(en),
    .bidir_reset_enable_o(bidir), .reset_output_pin_n_o(rout_n), .reset_input_pin_o(drv),
    .reset_input_pin_oe_o(oe), .internal_reset_o(irst), .async_quiesce_o(quiesce),
    .flash_ready_o(fready), .flash_read_data_o(fdata));
  wdrs_supervisor wdrs_supervisor_i (.hold_low_i(hold), .discharge_low_i(dlow), .dev_oe_i(oe),
    .dev_drv_i(drv), .reset_input_pin_n_o(pin_n), .reset_discharge_pin_o(reset_discharge_pin));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (oe === 1'b1) seen_oe <= 1'b1;
  task automatic cyc(input int k); repeat (k) @(posedge clk); #1; endtask : cyc
  task automatic pulse(input int k); req[k] = 1'b1; cyc(1); req[k] = 1'b0; endtask : pulse
  task automatic low(input int k); hold = 1'b1; cyc(k); hold = 1'b0; endtask : low
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  // Waits for the sequencer to return to run; n counts the cycles spent.
  task automatic wait_run();
    n = 4;
    cyc(4);
    while (irst !== 1'b0 && n < 3000) begin cyc(1); n++; end
    chk(irst === 1'b0, "stuck in reset");
  endtask : wait_run
  task automatic svc(input logic [7:0] r, input logic p);
    rel = r;
    pres = p;
    pulse(4);
    pulse(2);
    cyc(1);
  endtask : svc
  task automatic t_boot();
    chk(f.power_on_flag && f.long_hardware_flag && fdata === 16'hffff, "power-on");
    {hold, dlow} = 2'h0;
    wait_run();
    chk(n >= FI && n <= FI + 12 && fready && en && fdata === 16'h009b, "boot hold");
    pulse(3);
    cyc(2);
    chk(!en, "early disable");
    pulse(0);
    cyc(2);
    chk(f[5:1] === 5'h00 && rout_n, "init clear");
    $display("boot test done");
  endtask : t_boot
  task automatic t_soft();
    pulse(5);
    {dlow, seen_oe} = 2'h2;
    pulse(1);
    wait_run();
    chk(f.software_reset_flag && !seen_oe && !bidir && en, "soft reset");
    dlow = 1'b0;
    pulse(0);
    pulse(3);
    cyc(2);
    chk(en, "late disable");
    $display("software reset test done");
  endtask : t_soft
  task automatic t_wdt();
    pulse(5);
    seen_oe = 1'b0;
    svc(8'hff, 1'b0);
    chk(cnt === 16'hff00, "service load");
    n = 0;
    while (irst !== 1'b1 && n < 1000) begin cyc(1); n++; end
    chk(n >= 500 && n <= 525 && !rout_n, "timeout");
    wait_run();
    chk(f.timeout_reset_flag && seen_oe, "timeout flag");
    pulse(0);
    svc(8'h80, 1'b1);
    cyc(130);
    chk(cnt >= 16'h8001 && cnt <= 16'h8002, "slow prescale");
    $display("watchdog test done");
  endtask : t_wdt
  task automatic t_hw();
    pulse(0);
    cyc(2);
    low(1);
    cyc(10);
    chk(!irst, "spike");
    low(10);
    wait_run();
    chk(f.short_hardware_flag && !f.long_hardware_flag, "short reset");
    pulse(0);
    low(600);
    wait_run();
    chk(f.long_hardware_flag, "long reset");
    $display("hardware reset test done");
  endtask : t_hw
  task automatic t_async();
    pulse(0);
    {dlow, hold} = 2'h3;
    cyc(8);
    chk(quiesce && !rout_n, "async entry");
    {boot_n, hold} = 2'h0;
    wait_run();
    chk(n <= 12 && f.long_hardware_flag, "external boot exit");
    $display("asynchronous reset test done");
  endtask : t_async
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
  initial begin
    {n_errors, comparisons} = '0;
    {req, rel, pres, seen_oe} = 16'h0000;
    {rst, hold, dlow, boot_n} = 4'hf;
    cyc(20);
    rst = 1'b0;
    cyc(5);
    t_boot();
    t_soft();
    t_wdt();
    t_hw();
    t_async();
    conclude();
  end
endmodule : wdrs_top_bench
